// ---- logic/sie_pkg.sv ----
// shared constants and types for the sync/idle/event sequencer
package sie_pkg;

  localparam int          SIE_INSTR_W      = 16;
  localparam int          SIE_MASK_W       = 16;
  localparam int          SIE_DATA_W       = 32;
  localparam int          SIE_DREG_W       = 3;

  // instruction group codes presented by the decoder
  localparam logic [2:0]  SIE_OP_NONE      = 3'h0;
  localparam logic [2:0]  SIE_OP_IDLE      = 3'h1;
  localparam logic [2:0]  SIE_OP_CORE_SYNC = 3'h2;
  localparam logic [2:0]  SIE_OP_SYS_SYNC  = 3'h3;
  localparam logic [2:0]  SIE_OP_FORCE_EMU = 3'h4;
  localparam logic [2:0]  SIE_OP_INT_DIS   = 3'h5;
  localparam logic [2:0]  SIE_OP_INT_EN    = 3'h6;

  // register map on the bus (byte addresses)
  localparam logic [7:0]  SIE_OFS_SEQ_STATUS = 8'h00;
  localparam logic [7:0]  SIE_OFS_INT_MASK   = 8'h04;
  localparam logic [7:0]  SIE_OFS_STATUS     = 8'h08;
  localparam logic [7:0]  SIE_OFS_CTRL       = 8'h0c;

  // field positions
  localparam int          SIE_SEQ_IDLE_REQ = 0;
  localparam int          SIE_CTRL_EMU_EN  = 0;

  // reset values
  localparam logic [15:0] SIE_INT_MASK_RST = 16'h001f;
  localparam logic        SIE_EMU_EN_RST   = 1'b0;

  // exception cause codes
  localparam logic [1:0]  SIE_EXC_NONE     = 2'h0;
  localparam logic [1:0]  SIE_EXC_EMU      = 2'h1;
  localparam logic [1:0]  SIE_EXC_ILLEGAL  = 2'h2;
  localparam logic [1:0]  SIE_EXC_PROTECT  = 2'h3;

  typedef enum logic [2:0] {
    SIE_ST_READY,
    SIE_ST_DRAIN_CORE,
    SIE_ST_DRAIN_SYS,
    SIE_ST_SYNC_REQ,
    SIE_ST_IDLE
  } sie_state_type;

endpackage : sie_pkg

// ---- logic/sie_sequencer.sv ----
// sync, idle and interrupt-mask event sequencer with AHB-Lite status port
`timescale 1ns/1ps
`default_nettype none

module sie_sequencer
  import sie_pkg::*;
#(
  parameter int MASK_W = SIE_MASK_W
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [7:0]             haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // decoder side
  input  wire logic                   instr_valid,
  input  wire logic [2:0]             instr_op,
  input  wire logic [SIE_INSTR_W-1:0] instr_word,
  input  wire logic                   instr_16bit,
  input  wire logic                   instr_parallel,
  input  wire logic                   supervisor_mode,
  input  wire logic [SIE_DREG_W-1:0]  instr_dreg,
  input  wire logic [SIE_DATA_W-1:0]  dreg_rdata,
  output logic                        instr_ready,
  output logic                        instr_done,
  output logic                        dreg_we,
  output logic      [SIE_DREG_W-1:0]  dreg_waddr,
  output logic      [SIE_DATA_W-1:0]  dreg_wdata,
  // pipeline and memory status
  input  wire logic                   spec_pending,
  input  wire logic                   store_buf_empty,
  input  wire logic                   write_buf_empty,
  input  wire logic                   nmi_req,
  output logic                        issue_hold,
  output logic                        spec_load_block,
  output logic                        store_buf_drain,
  output logic                        write_buf_drain,
  output logic                        resume_next,
  // exceptions
  output logic                        exc_valid,
  output logic      [1:0]             exc_cause,
  output logic                        nmi_take,
  output logic      [MASK_W-1:0]      interrupt_mask,
  // system clock and power controller
  input  wire logic                   sync_ack,
  input  wire logic                   wakeup,
  output logic                        sync_req,
  output logic                        idle_out
);

  typedef struct packed {
    sie_state_type         state;
    logic                  idle_req;
    logic                  emu_en;
    logic [MASK_W-1:0]     int_mask;
    logic                  ap_valid;
    logic                  ap_write;
    logic [7:0]            ap_addr;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  hresp;
    logic                  instr_ready;
    logic                  issue_hold;
    logic                  instr_done;
    logic                  dreg_we;
    logic [SIE_DREG_W-1:0] dreg_waddr;
    logic [SIE_DATA_W-1:0] dreg_wdata;
    logic                  spec_block;
    logic                  sb_drain;
    logic                  wb_drain;
    logic                  resume;
    logic                  exc_valid;
    logic [1:0]            exc_cause;
    logic                  nmi_take;
    logic                  sync_req;
    logic                  idle_out;
  } sie_regs_type;

  sie_regs_type r_reg;
  sie_regs_type r_next;

  logic take;
  logic standalone_ok;
  logic priv_op;

  function automatic logic [31:0] sie_read(input logic [7:0] a, input sie_regs_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      SIE_OFS_SEQ_STATUS: v[SIE_SEQ_IDLE_REQ] = s.idle_req;
      SIE_OFS_INT_MASK:   v[MASK_W-1:0]       = s.int_mask;
      SIE_OFS_STATUS:     v[2:0]              = s.state;
      SIE_OFS_CTRL:       v[SIE_CTRL_EMU_EN]  = s.emu_en;
      default:            v = 32'h0000_0000;
    endcase
    return v;
  endfunction : sie_read

  // a write lands in its data phase, one cycle after the address was taken
  function automatic logic sie_wr_hit(input sie_regs_type s, input logic [7:0] ofs);
    return s.ap_valid && s.ap_write && (s.ap_addr == ofs);
  endfunction : sie_wr_hit

  assign take          = instr_valid && r_reg.instr_ready;
  assign standalone_ok = instr_16bit && !instr_parallel && (instr_word != 16'h0000);
  assign priv_op       = (instr_op == SIE_OP_IDLE) || (instr_op == SIE_OP_INT_DIS) || (instr_op == SIE_OP_INT_EN);

  always_comb begin
    r_next             = r_reg;
    r_next.instr_done  = 1'b0;
    r_next.dreg_we     = 1'b0;
    r_next.exc_valid   = 1'b0;
    r_next.exc_cause   = SIE_EXC_NONE;
    r_next.resume      = 1'b0;
    r_next.nmi_take    = nmi_req;

    // bus: single-cycle data phase, always ready and OKAY
    // an instruction in the same cycle overrides a bus write to the mask
    if (sie_wr_hit(r_reg, SIE_OFS_INT_MASK)) begin
      r_next.int_mask = hwdata[MASK_W-1:0];
    end
    if (sie_wr_hit(r_reg, SIE_OFS_CTRL)) begin
      r_next.emu_en = hwdata[SIE_CTRL_EMU_EN];
    end
    // writes to sequencer status are dropped on purpose
    r_next.ap_valid = hsel && hready && htrans[1];
    r_next.ap_write = hwrite;
    r_next.ap_addr  = haddr;
    r_next.hrdata   = sie_read(haddr, r_reg);

    unique case (r_reg.state)
      SIE_ST_READY: begin
        if (take) begin
          if (!standalone_ok) begin
            r_next.exc_valid  = 1'b1;
            r_next.exc_cause  = SIE_EXC_ILLEGAL;
            r_next.instr_done = 1'b1;
          end else if (instr_op == SIE_OP_FORCE_EMU) begin
            // emulation is checked after the encoding check and ahead of the supervisor check, so user mode can raise it
            r_next.exc_valid  = 1'b1;
            r_next.exc_cause  = r_reg.emu_en ? SIE_EXC_EMU : SIE_EXC_ILLEGAL;
            r_next.instr_done = 1'b1;
          end else if (priv_op && !supervisor_mode) begin
            r_next.exc_valid  = 1'b1;
            r_next.exc_cause  = SIE_EXC_PROTECT;
            r_next.instr_done = 1'b1;
          end else begin
            unique case (instr_op)
              SIE_OP_IDLE: begin
                r_next.idle_req   = 1'b1;
                r_next.instr_done = 1'b1;
              end
              SIE_OP_INT_DIS: begin
                r_next.dreg_we    = 1'b1;
                r_next.dreg_waddr = instr_dreg;
                r_next.dreg_wdata = SIE_DATA_W'(r_reg.int_mask);
                r_next.int_mask   = '0;
                r_next.instr_done = 1'b1;
              end
              SIE_OP_INT_EN: begin
                r_next.int_mask   = dreg_rdata[MASK_W-1:0];
                r_next.instr_done = 1'b1;
              end
              SIE_OP_CORE_SYNC, SIE_OP_SYS_SYNC: begin
                r_next.instr_ready = 1'b0;
                r_next.sb_drain    = 1'b1;
                r_next.spec_block  = 1'b1;
                r_next.state       = (instr_op == SIE_OP_SYS_SYNC) ? SIE_ST_DRAIN_SYS : SIE_ST_DRAIN_CORE;
              end
              default: begin
                r_next.exc_valid  = 1'b1;
                r_next.exc_cause  = SIE_EXC_ILLEGAL;
                r_next.instr_done = 1'b1;
              end
            endcase
          end
        end
      end
      SIE_ST_DRAIN_CORE: begin
        if (!spec_pending && store_buf_empty) begin
          r_next.sb_drain    = 1'b0;
          r_next.spec_block  = 1'b0;
          r_next.instr_done  = 1'b1;
          r_next.instr_ready = 1'b1;
          r_next.state       = SIE_ST_READY;
        end
      end
      SIE_ST_DRAIN_SYS: begin
        r_next.wb_drain = 1'b1;
        if (!spec_pending && store_buf_empty && write_buf_empty && r_reg.wb_drain) begin
          r_next.sb_drain = 1'b0;
          r_next.wb_drain = 1'b0;
          r_next.sync_req = 1'b1;
          r_next.state    = SIE_ST_SYNC_REQ;
        end
      end
      SIE_ST_SYNC_REQ: begin
        if (sync_ack) begin
          r_next.sync_req = 1'b0;
          if (r_reg.idle_req) begin
            r_next.idle_out = 1'b1;
            r_next.state    = SIE_ST_IDLE;
          end else begin
            r_next.spec_block  = 1'b0;
            r_next.instr_done  = 1'b1;
            r_next.instr_ready = 1'b1;
            r_next.state       = SIE_ST_READY;
          end
        end
      end
      SIE_ST_IDLE: begin
        // the clock may be stopped here; nothing counts edges while waiting
        if (wakeup) begin
          r_next.idle_out    = 1'b0;
          r_next.idle_req    = 1'b0;
          r_next.spec_block  = 1'b0;
          r_next.instr_done  = 1'b1;
          r_next.resume      = 1'b1;
          r_next.instr_ready = 1'b1;
          r_next.state       = SIE_ST_READY;
        end
      end
      default: r_next.state = SIE_ST_READY;
    endcase

    // hold is kept as its own flop so the output carries no gate after the register
    r_next.issue_hold = !r_next.instr_ready;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg             <= '0;
      r_reg.state       <= SIE_ST_READY;
      r_reg.int_mask    <= MASK_W'(SIE_INT_MASK_RST);
      r_reg.hreadyout   <= 1'b1;
      r_reg.emu_en      <= SIE_EMU_EN_RST;
      r_reg.instr_ready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata          = r_reg.hrdata;
  assign hreadyout       = r_reg.hreadyout;
  assign hresp           = r_reg.hresp;
  assign instr_ready     = r_reg.instr_ready;
  assign instr_done      = r_reg.instr_done;
  assign dreg_we         = r_reg.dreg_we;
  assign dreg_waddr      = r_reg.dreg_waddr;
  assign dreg_wdata      = r_reg.dreg_wdata;
  assign issue_hold      = r_reg.issue_hold;
  assign spec_load_block = r_reg.spec_block;
  assign store_buf_drain = r_reg.sb_drain;
  assign write_buf_drain = r_reg.wb_drain;
  assign resume_next     = r_reg.resume;
  assign exc_valid       = r_reg.exc_valid;
  assign exc_cause       = r_reg.exc_cause;
  assign nmi_take        = r_reg.nmi_take;
  assign interrupt_mask  = r_reg.int_mask;
  assign sync_req        = r_reg.sync_req;
  assign idle_out        = r_reg.idle_out;

endmodule : sie_sequencer

`default_nettype wire

// ---- verif/sie_sequencer_sva.sv ----
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sie_sequencer_sva
  import sie_pkg::*;
#(
  parameter int MASK_W = SIE_MASK_W
) (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   instr_valid,
  input wire logic                   instr_ready,
  input wire logic [2:0]             instr_op,
  input wire logic [SIE_INSTR_W-1:0] instr_word,
  input wire logic                   instr_16bit,
  input wire logic                   instr_parallel,
  input wire logic                   supervisor_mode,
  input wire logic [SIE_DATA_W-1:0]  dreg_rdata,
  input wire logic                   exc_valid,
  input wire logic [1:0]             exc_cause,
  input wire logic                   nmi_req,
  input wire logic                   nmi_take,
  input wire logic [MASK_W-1:0]      interrupt_mask,
  input wire logic                   resume_next,
  input wire logic                   write_buf_empty,
  input wire logic                   sync_ack,
  input wire logic                   wakeup,
  input wire logic                   sync_req,
  input wire logic                   idle_out
);
  logic take;
  logic priv;
  assign take = instr_valid & instr_ready;
  // of the instructions, only a well formed supervisor issue may touch the mask
  assign priv = take & supervisor_mode & instr_16bit & ~instr_parallel & (|instr_word);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sync_hold_a: assert property (sync_req && !sync_ack |=> sync_req) else $error("sync_req dropped");
  sync_drop_a: assert property (sync_req && sync_ack |=> !sync_req) else $error("sync_req stuck");
  idle_hold_a: assert property (idle_out && !wakeup |=> idle_out) else $error("idle left early");
  idle_exit_a: assert property (idle_out && wakeup |=> !idle_out && resume_next) else $error("no resume");
  issue_block_a: assert property (sync_req || idle_out |-> !instr_ready) else $error("issue open");
  nmi_pass_a: assert property (1'b1 |=> nmi_take == $past(nmi_req)) else $error("nmi lost");
  par_illegal_a: assert property (take && instr_parallel |=>
    exc_valid && exc_cause == SIE_EXC_ILLEGAL) else $error("parallel issue accepted");
  mask_clear_a: assert property (priv && instr_op == SIE_OP_INT_DIS |=>
    interrupt_mask == '0) else $error("mask kept");
  mask_load_a: assert property (priv && instr_op == SIE_OP_INT_EN |=>
    interrupt_mask == MASK_W'($past(dreg_rdata))) else $error("mask not loaded");
  drain_first_a: assert property ($rose(sync_req) |-> $past(write_buf_empty)) else $error("early request");
  idle_seen_c: cover property ($rose(idle_out));
  ack_seen_c: cover property (sync_req && sync_ack);
  emu_seen_c: cover property (exc_valid && exc_cause == SIE_EXC_EMU);
endmodule : sie_sequencer_sva

bind sie_sequencer sie_sequencer_sva #(.MASK_W(MASK_W)) sie_sequencer_sva_i (
  .hclk, .hresetn, .instr_valid, .instr_ready, .instr_op, .instr_word, .instr_16bit, .instr_parallel,
  .supervisor_mode, .dreg_rdata, .exc_valid, .exc_cause, .nmi_req, .nmi_take, .interrupt_mask,
  .resume_next, .write_buf_empty, .sync_ack, .wakeup, .sync_req, .idle_out);
`default_nettype wire

// ---- verif/sie_sequencer_tb.sv ----
// self-checking bench for the sync and idle sequencer
`timescale 1ns/1ps
`default_nettype none
module sie_sequencer_tb
  import sie_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, instr_valid = 1'b0;
  logic        instr_parallel = 1'b0, supervisor_mode = 1'b1, spec_pending = 1'b0, nmi_req = 1'b0;
  logic        instr_16bit = 1'b1, store_buf_empty = 1'b1, write_buf_empty = 1'b1, wake_cmd = 1'b0;
  logic [7:0]  haddr = 8'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, instr_op = 3'h0, instr_dreg = 3'h0;
  logic [31:0] hwdata = 32'h0, dreg_rdata = 32'h0, rdv, hrdata, dreg_wdata;
  logic [15:0] instr_word = 16'h0001, interrupt_mask;
  logic [3:0]  ack_dly = 4'h0;
  logic [2:0]  dreg_waddr;
  logic [1:0]  exc_cause;
  logic        hready, hreadyout, hresp, instr_ready, instr_done, dreg_we, issue_hold, spec_load_block;
  logic        store_buf_drain, write_buf_drain, resume_next, exc_valid, nmi_take, sync_ack, wakeup;
  logic        sync_req, idle_out;
  int          miscompares, compares, cycles;
  assign hready = hreadyout;
  sie_sequencer sie_sequencer_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .instr_valid, .instr_op, .instr_word, .instr_16bit, .instr_parallel, .supervisor_mode, .instr_dreg,
    .dreg_rdata, .instr_ready, .instr_done, .dreg_we, .dreg_waddr, .dreg_wdata, .spec_pending,
    .store_buf_empty, .write_buf_empty, .nmi_req, .issue_hold, .spec_load_block, .store_buf_drain,
    .write_buf_drain, .resume_next, .exc_valid, .exc_cause, .nmi_take, .interrupt_mask, .sync_ack,
    .wakeup, .sync_req, .idle_out);
  sie_sys_ctrl sie_sys_ctrl_i (.hclk, .hresetn, .sync_req, .idle_out, .ack_dly, .wake_cmd, .sync_ack, .wakeup);
  initial begin
    forever #20 hclk = ~hclk;
  end
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // returns one edge after the take, while the one-cycle answer still stands
  task automatic issue(logic [2:0] op, logic sup, logic par);
    @(posedge hclk);
    instr_valid     <= 1'b1;
    instr_op        <= op;
    supervisor_mode <= sup;
    instr_parallel  <= par;
    do @(posedge hclk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    @(posedge hclk);
  endtask : issue
  task automatic t_mask();
    nmi_req    <= 1'b1;
    instr_dreg <= 3'h5;
    issue(SIE_OP_INT_DIS, 1'b1, 1'b0);
    chk("dreg_we", {dreg_we, dreg_waddr}, {1'b1, 3'h5});
    chk("dreg_wdata", dreg_wdata, SIE_INT_MASK_RST);
    chk("mask", interrupt_mask, 16'h0);
    chk("nmi_take", nmi_take, 1'b1);
    dreg_rdata <= 32'h0000_00a5;
    issue(SIE_OP_INT_EN, 1'b1, 1'b0);
    bus(1'b0, SIE_OFS_INT_MASK, 32'h0, rdv);
    chk("mask", rdv, 32'h0000_00a5);
    chk("resp", {hresp, hreadyout}, 2'h1);
    nmi_req <= 1'b0;
    $display("test mask done");
  endtask : t_mask
  task automatic t_fault();
    logic [2:0] prot [3] = '{SIE_OP_IDLE, SIE_OP_INT_DIS, SIE_OP_INT_EN};
    dreg_rdata <= 32'h0;
    foreach (prot[i]) begin
      issue(prot[i], 1'b0, 1'b0);
      chk("exc", {exc_valid, exc_cause}, {1'b1, SIE_EXC_PROTECT});
    end
    chk("mask", interrupt_mask, 16'h00a5);
    issue(SIE_OP_CORE_SYNC, 1'b1, 1'b1);
    chk("exc", {exc_valid, exc_cause}, {1'b1, SIE_EXC_ILLEGAL});
    instr_16bit <= 1'b0;
    issue(SIE_OP_IDLE, 1'b1, 1'b0);
    chk("exc", {exc_valid, exc_cause}, {1'b1, SIE_EXC_ILLEGAL});
    instr_16bit <= 1'b1;
    instr_word  <= 16'h0000;
    issue(SIE_OP_INT_EN, 1'b1, 1'b0);
    chk("exc", {exc_valid, exc_cause}, {1'b1, SIE_EXC_ILLEGAL});
    chk("mask", interrupt_mask, 16'h00a5);
    instr_word  <= 16'h0001;
    issue(SIE_OP_FORCE_EMU, 1'b1, 1'b0);
    chk("exc", {exc_valid, exc_cause}, {1'b1, SIE_EXC_ILLEGAL});
    bus(1'b1, SIE_OFS_CTRL, 32'h1, rdv);
    issue(SIE_OP_FORCE_EMU, 1'b0, 1'b0);
    chk("exc", {exc_valid, exc_cause}, {1'b1, SIE_EXC_EMU});
    $display("test fault done");
  endtask : t_fault
  task automatic t_csync();
    int n;
    spec_pending    <= 1'b1;
    store_buf_empty <= 1'b0;
    issue(SIE_OP_CORE_SYNC, 1'b1, 1'b0);
    spec_pending <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("drain", {instr_ready, issue_hold, spec_load_block, store_buf_drain}, 4'h7);
    store_buf_empty <= 1'b1;
    for (n = 0; n < 20 && instr_done !== 1'b1; n++) @(posedge hclk);
    chk("done", {instr_done, spec_load_block, issue_hold}, 3'h4);
    $display("test csync done");
  endtask : t_csync
  task automatic t_idle();
    int n;
    bus(1'b1, SIE_OFS_SEQ_STATUS, 32'h1, rdv);
    bus(1'b0, SIE_OFS_SEQ_STATUS, 32'h0, rdv);
    chk("stat", rdv, 32'h0);
    issue(SIE_OP_IDLE, 1'b1, 1'b0);
    bus(1'b0, SIE_OFS_SEQ_STATUS, 32'h0, rdv);
    chk("stat", rdv, 32'h1);
    write_buf_empty <= 1'b0;
    ack_dly         <= 4'h3;
    issue(SIE_OP_SYS_SYNC, 1'b1, 1'b0);
    repeat (5) @(posedge hclk);
    chk("drain", {sync_req, write_buf_drain, instr_ready}, 3'h2);
    write_buf_empty <= 1'b1;
    for (n = 0; n < 30 && idle_out !== 1'b1; n++) @(posedge hclk);
    repeat (6) @(posedge hclk);
    chk("idle", {idle_out, sync_req, instr_ready}, 3'h4);
    bus(1'b0, SIE_OFS_STATUS, 32'h0, rdv);
    chk("state", rdv, 32'(SIE_ST_IDLE));
    wake_cmd <= 1'b1;
    for (n = 0; n < 10 && resume_next !== 1'b1; n++) @(posedge hclk);
    chk("resume", {resume_next, instr_done}, 2'h3);
    wake_cmd <= 1'b0;
    bus(1'b0, SIE_OFS_SEQ_STATUS, 32'h0, rdv);
    chk("stat", {rdv[0], idle_out}, 2'h0);
    $display("test idle done");
  endtask : t_idle
  task automatic t_ssync();
    logic [3:0] dly [2] = '{4'h0, 4'h6};
    int n, hits;
    foreach (dly[i]) begin
      ack_dly <= dly[i];
      hits = 0;
      issue(SIE_OP_SYS_SYNC, 1'b1, 1'b0);
      for (n = 0; n < 30 && instr_done !== 1'b1; n++) begin
        @(posedge hclk);
        hits += int'(sync_req === 1'b1);
      end
      chk("req cycles", hits, dly[i] + 2);
      chk("idle", idle_out, 1'b0);
    end
    $display("test ssync done");
  endtask : t_ssync
  // ceiling well above the hundred or so cycles the tests need
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_mask();
    t_fault();
    t_csync();
    t_idle();
    t_ssync();
    summarize();
  end
endmodule : sie_sequencer_tb
`default_nettype wire

// ---- verif/sie_sys_ctrl.sv ----
// behavioural system clock and power controller
`timescale 1ns/1ps
`default_nettype none
module sie_sys_ctrl (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       sync_req,
  input  wire logic       idle_out,
  input  wire logic [3:0] ack_dly,
  input  wire logic       wake_cmd,
  output logic            sync_ack,
  output logic            wakeup
);
  logic [3:0] cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg  <= 4'h0;
      sync_ack <= 1'b0;
      wakeup   <= 1'b0;
    end else begin
      cnt_reg  <= sync_req ? cnt_reg + 4'h1 : 4'h0;
      // one-cycle answer after a chosen wait, so slow answers get tested
      sync_ack <= sync_req && !sync_ack && cnt_reg >= ack_dly;
      // clock left running in idle, the simplest legal choice
      wakeup   <= wake_cmd && idle_out && !wakeup;
    end
  end
endmodule : sie_sys_ctrl
`default_nettype wire
